/* File: design/wzp_top.sv */
// wrapped coordinate, offset window, setting error and segment boundary pulse
// Operation
// (RULE1) wrap boundary sits at an adjustable offset from mechanical home
// (RULE2) ratio setting shifts the range negative by that fraction of its length
// (RULE3) the signed offset value then shifts the window further by steps
// (RULE4) info flag raised when the window does not contain home; the code raises it only while host_cfg.wrap_enable is set
// (RULE5) info present at power-up or configuration escalates to an alarm
// (RULE6) range split into equal segments from home; pulse on each boundary; the code counts segments from the position at reset or last configuration
// (RULE7) division count 1 to 536,870,911, default 1
// (RULE8) boundary pulse only while wrapping is enabled
// (RULE9) offset ratio 0 to 10,000 in 0.01 percent, default 5,000
// (RULE10) offset value signed, -536,870,912 to 536,870,911, default 0
// (RULE11) with wrapping, coordinate returns over the window each full range
// (RULE12) boundary pulse is one registered cycle, either travel direction
`include "wzp_defs.svh"
`default_nettype none
module wzp_top
  import wzp_pkg::*;
#(
  parameter logic [31:0] RANGE_DEFAULT = 32'h0112A880,
  parameter logic WRAP_DEFAULT = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire wzp_cfg_t host_cfg,
  input wire logic config_execute,
  input wire logic alarm_clear,
  input wire logic step_pulse,
  input wire logic step_forward,
  output logic signed [33:0] wrap_position,
  output logic segment_boundary_pulse,
  output logic wrap_setting_info,
  output logic wrap_setting_alarm
);

  ////////////////////////////////////////////////////////////////////////
  // window arithmetic

  // low = offset - range*ratio/10000, high = low + range - 1
  function automatic wzp_win_t calc_window(input wzp_cfg_t c);
    logic [45:0] prod;
    logic [45:0] shift;
    logic [13:0] r;
    wzp_win_t w;
    r = (c.ratio > `WZP_RATIO_FULL) ? `WZP_RATIO_FULL : c.ratio; // RULE9
    prod = {14'h0000, c.range} * {32'h00000000, r};
    shift = prod / {32'h00000000, `WZP_RATIO_FULL}; // RULE2
    w.low = {{4{c.offset[29]}}, c.offset} - {2'b00, shift[31:0]}; // RULE3 RULE10
    w.high = w.low + {2'b00, c.range} - 34'sh000000001; // RULE1
    w.home_ok = (w.low <= 34'sh000000000) && (w.high >= 34'sh000000000);
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // active settings: defaults at power-up, host values on configuration

  wzp_cfg_t act;
  always_ff @(posedge clk) begin
    if (reset) begin
      act.wrap_enable <= WRAP_DEFAULT;
      act.range <= RANGE_DEFAULT;
      act.ratio <= `WZP_RATIO_DEFAULT; // RULE9
      act.offset <= `WZP_OFFSET_DEFAULT; // RULE10
      act.divisions <= `WZP_DIV_DEFAULT; // RULE7
    end else if (config_execute) begin
      act <= host_cfg;
    end
  end

  wzp_win_t host_win;
  wzp_win_t act_win;
  logic [31:0] range_eff;
  logic [31:0] div_eff;
  logic next_info;
  always_comb begin
    host_win = calc_window(host_cfg);
    act_win = calc_window(act);
    // a zero range would freeze the segment counter, so treat it as one step
    range_eff = (act.range == 32'h00000000) ? 32'h00000001 : act.range;
    // more than one boundary per step cannot be shown, so cap at range
    if (act.divisions < `WZP_DIV_MIN) begin
      div_eff = {3'b000, `WZP_DIV_MIN}; // RULE7
    end else begin
      div_eff = {3'b000, act.divisions};
    end
    if (div_eff > range_eff) begin
      div_eff = range_eff;
    end
    next_info = host_cfg.wrap_enable && !host_win.home_ok; // RULE4
  end

  ////////////////////////////////////////////////////////////////////////
  // setting error information and alarm

  // power-up check needs the first cycle after release
  logic power_pending;
  always_ff @(posedge clk) begin
    if (reset) begin
      power_pending <= 1'b1;
    end else begin
      power_pending <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      wrap_setting_info <= 1'b0;
    end else begin
      wrap_setting_info <= next_info; // RULE4
    end
  end

  // escalation wins over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      wrap_setting_alarm <= 1'b0;
    end else if ((config_execute || power_pending) && next_info) begin
      wrap_setting_alarm <= 1'b1; // RULE5
    end else if (alarm_clear) begin
      wrap_setting_alarm <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // wrapped coordinate

  always_ff @(posedge clk) begin
    if (reset) begin
      wrap_position <= 34'sh000000000;
    end else if (step_pulse) begin
      if (step_forward) begin
        if (act.wrap_enable && wrap_position >= act_win.high) begin
          wrap_position <= act_win.low; // RULE11
        end else begin
          wrap_position <= wrap_position + 34'sh000000001;
        end
      end else begin
        if (act.wrap_enable && wrap_position <= act_win.low) begin
          wrap_position <= act_win.high; // RULE11
        end else begin
          wrap_position <= wrap_position - 34'sh000000001;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // segment phase: acc = (distance from the position at reset or last configuration * divisions) mod range

  logic [31:0] acc;
  logic [32:0] acc_up;
  logic crossing;
  always_comb begin
    acc_up = {1'b0, acc} + {1'b0, div_eff};
    if (step_forward) begin
      crossing = acc_up >= {1'b0, range_eff}; // RULE6
    end else begin
      crossing = acc < div_eff; // RULE6
    end
  end

  always_ff @(posedge clk) begin
    if (reset || config_execute) begin
      acc <= 32'h00000000; // the position at reset or configuration is a boundary
    end else if (step_pulse) begin
      if (step_forward) begin
        acc <= crossing ? 32'(acc_up - {1'b0, range_eff}) : acc_up[31:0];
      end else begin
        acc <= crossing ? (acc + range_eff - div_eff) : (acc - div_eff);
      end
    end
  end

  // one-cycle pulse, held low while wrapping is off
  always_ff @(posedge clk) begin
    if (reset) begin
      segment_boundary_pulse <= 1'b0;
    end else begin
      segment_boundary_pulse <= step_pulse && crossing && act.wrap_enable; // RULE8 RULE12
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  pulse_off_disabled_a: assert property (@(posedge clk) disable iff (reset) // RULE8
    !act.wrap_enable |=> !segment_boundary_pulse)
    else $error("boundary pulse while wrapping disabled");

  pulse_needs_step_a: assert property (@(posedge clk) disable iff (reset) // RULE12
    segment_boundary_pulse |-> $past(step_pulse) && !$past(reset))
    else $error("boundary pulse without a step");

  pulse_single_a: assert property (@(posedge clk) disable iff (reset) // RULE12
    (step_pulse && crossing && act.wrap_enable) ##1 !step_pulse |=> !segment_boundary_pulse)
    else $error("boundary pulse longer than one cycle");

  info_tracks_a: assert property (@(posedge clk) disable iff (reset) // RULE4
    !$past(reset) |-> wrap_setting_info == $past(host_cfg.wrap_enable && !host_win.home_ok))
    else $error("setting info does not follow window check");

  alarm_escalate_a: assert property (@(posedge clk) disable iff (reset) // RULE5
    config_execute && next_info |=> wrap_setting_alarm)
    else $error("alarm not raised on configuration with info");

  alarm_cause_a: assert property (@(posedge clk) disable iff (reset) // RULE5
    $rose(wrap_setting_alarm) |-> $past(config_execute || power_pending) && $past(next_info))
    else $error("alarm raised without cause");

  wrap_forward_a: assert property (@(posedge clk) disable iff (reset) // RULE11
    step_pulse && step_forward && act.wrap_enable && wrap_position == act_win.high
    |=> wrap_position == $past(act_win.low))
    else $error("forward wrap missed the window low end");

  stay_in_window_a: assert property (@(posedge clk) disable iff (reset) // RULE1
    act.wrap_enable && !config_execute && wrap_position >= act_win.low
    && wrap_position <= act_win.high
    |=> wrap_position >= act_win.low && wrap_position <= act_win.high)
    else $error("coordinate left its window");

  phase_bounded_a: assert property (@(posedge clk) disable iff (reset) // RULE6
    !config_execute && acc < range_eff |=> acc < range_eff || $past(config_execute))
    else $error("segment phase out of range");

  div_floor_a: assert property (@(posedge clk) disable iff (reset) // RULE7
    div_eff >= 32'h00000001 && div_eff <= range_eff)
    else $error("division count outside usable range");

endmodule // wzp_top
`default_nettype wire

/* File: shared/wzp_defs.svh */
// timing-free constants for the wrap offset and zone pulse block
`ifndef WZP_DEFS_SVH
`define WZP_DEFS_SVH
// offset ratio: full scale 10,000 = 100.00 %, default 5,000
`define WZP_RATIO_FULL 14'h2710
`define WZP_RATIO_DEFAULT 14'h1388
// offset value default, in steps
`define WZP_OFFSET_DEFAULT 30'h00000000
// division count limits and default
`define WZP_DIV_MIN 29'h00000001
`define WZP_DIV_MAX 29'h1FFFFFFF
`define WZP_DIV_DEFAULT 29'h00000001
`endif

/* File: shared/wzp_pkg.sv */
// types shared by the wrap offset and zone pulse block
`default_nettype none
package wzp_pkg;
  // one full set of wrap settings
  typedef struct packed {
    logic wrap_enable;
    logic [31:0] range;
    logic [13:0] ratio;
    logic signed [29:0] offset;
    logic [28:0] divisions;
  } wzp_cfg_t;
  // coordinate window derived from a settings set
  typedef struct packed {
    logic signed [33:0] low;
    logic signed [33:0] high;
    logic home_ok;
  } wzp_win_t;
endpackage
`default_nettype wire

/* File: test/wzp_host.sv */
// host controller model: drives settings, configuration and motor steps
`default_nettype none
module wzp_host
  import wzp_pkg::*;
(
  input wire logic clk,
  output wzp_cfg_t host_cfg,
  output logic config_execute,
  output logic alarm_clear,
  output logic step_pulse,
  output logic step_forward
);
  timeunit 1ns;
  timeprecision 100ps;
  // quiet start: wrapping off so the power-up check stays clean
  initial begin
    host_cfg = '{1'b0, 32'h00000004, 14'h1388, 30'h00000000, 29'h00000002};
    {config_execute, alarm_clear, step_pulse, step_forward} = 4'h0;
  end
  // every change lands 1 ns after an edge and holds for one whole cycle
  task automatic set_cfg(input wzp_cfg_t c, input logic exec);
    @(posedge clk);
    #1;
    host_cfg = c;
    config_execute = exec;
    @(posedge clk);
    #1;
    config_execute = 1'b0;
  endtask
  task automatic step(input logic fwd);
    @(posedge clk);
    #1;
    step_forward = fwd;
    step_pulse = 1'b1;
    @(posedge clk);
    #1;
    step_pulse = 1'b0;
  endtask
  task automatic clear;
    @(posedge clk);
    #1;
    alarm_clear = 1'b1;
    @(posedge clk);
    #1;
    alarm_clear = 1'b0;
  endtask
endmodule // wzp_host
`default_nettype wire

/* File: test/wzp_top_bench.sv */
// self-checking bench for the wrap offset and zone pulse block
`default_nettype none
module wzp_top_bench;
  import wzp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, config_execute, alarm_clear, step_pulse, step_forward;
  wzp_cfg_t host_cfg, c;
  logic signed [33:0] wrap_position, pos;
  logic segment_boundary_pulse, wrap_setting_info, wrap_setting_alarm;
  logic [34:0] exp_q[$];
  int error_cnt, checks_done, acc;
  logic [13:0] rt[6] = '{14'h3FFF, 14'h0000, 14'h2710, 14'h2710, 14'h1388, 14'h1388};
  logic [29:0] of[6] = '{30'h1, 30'h3FFFFFFC, 30'h0, 30'h1, 30'h2, 30'h3};
  logic bad[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
  int divs[3] = '{1, 2, 4};
  ////////////////////////////////////////////////////////////////////////
  wzp_top u_dut (.clk(clk), .reset(reset), .host_cfg(host_cfg),
    .config_execute(config_execute), .alarm_clear(alarm_clear), .step_pulse(step_pulse),
    .step_forward(step_forward), .wrap_position(wrap_position),
    .segment_boundary_pulse(segment_boundary_pulse), .wrap_setting_info(wrap_setting_info),
    .wrap_setting_alarm(wrap_setting_alarm));
  wzp_host u_host (.clk(clk), .host_cfg(host_cfg), .config_execute(config_execute),
    .alarm_clear(alarm_clear), .step_pulse(step_pulse), .step_forward(step_forward));
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [34:0] seen, input logic [34:0] want);
    checks_done++;
    if (seen !== want) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // window is -2..1 for range 4, ratio 50 %, offset 0; acc tracks segment phase
  task automatic go(input logic fwd, input logic en, input int div);
    logic pls;
    pls = 1'b0;
    if (fwd) begin
      pos = (en && pos == 1) ? -34'sd2 : pos + 1;
      acc += div;
      if (acc >= 4) begin
        acc -= 4;
        pls = en;
      end
    end else begin
      pos = (en && pos == -2) ? 34'sd1 : pos - 1;
      if (acc < div) begin
        acc += 4;
        pls = en;
      end
      acc -= div;
    end
    exp_q.push_back({pos, pls});
    u_host.step(fwd);
  endtask
  // monitor: a step seen at an edge must answer right after it; otherwise no pulse
  always @(posedge clk) begin
    logic took;
    took = step_pulse;
    #2;
    if (took === 1'b1 && exp_q.size() > 0)
      check({wrap_position, segment_boundary_pulse}, exp_q.pop_front());
    else
      check(segment_boundary_pulse, 35'h0);
  end
  ////////////////////////////////////////////////////////////////////////
  // hang guard: the sequence needs well under this
  initial begin
    #2ms;
    error_cnt++;
    conclude();
  end
  initial begin
    reset = 1'b1;
    pos = '0;
    void'($urandom(72106));
    repeat (5) @(posedge clk);
    #1 reset = 1'b0;
    // windows on either side of home; info only, no escalation without config
    // the first entry has an over-range ratio, which must saturate to full scale
    for (int i = 0; i < 6; i++) begin
      c = '{1'b1, 32'h00000004, rt[i], of[i], 29'h00000002};
      u_host.set_cfg(c, 1'b0);
      @(posedge clk);
      #2;
      check(wrap_setting_info, bad[i]);
      check(wrap_setting_alarm, 35'h0);
    end
    u_host.set_cfg(c, 1'b1);
    @(posedge clk);
    #2;
    check(wrap_setting_alarm, 35'h1);
    // the good settings sticking here stay loaded for the step runs
    for (int d = 0; d < 3; d++) begin
      c = '{1'b1, 32'h00000004, 14'h1388, 30'h0, 29'(divs[d])};
      u_host.set_cfg(c, 1'b1);
      if (d == 0) begin
        u_host.clear();
        @(posedge clk);
        #2;
        check(wrap_setting_alarm, 35'h0);
      end
      acc = 0;
      repeat (16) go(1'($urandom % 2), 1'b1, divs[d]);
    end
    // wrapping off: no pulses and no return at the window ends
    c.wrap_enable = 1'b0;
    c.divisions = 29'h00000002;
    u_host.set_cfg(c, 1'b1);
    repeat (8) go(1'($urandom % 2), 1'b0, 2);
    // power cycle with a bad pending window escalates in the first cycle after release
    c = '{1'b1, 32'h00000004, 14'h1388, 30'h00000003, 29'h00000002};
    u_host.set_cfg(c, 1'b0);
    @(posedge clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge clk);
    #1 reset = 1'b0;
    @(posedge clk);
    #2;
    check(wrap_setting_alarm, 35'h1);
    check(wrap_setting_info, 35'h1);
    check(wrap_position, 35'h0);
    // with no power-up or configuration pending, a clear drops the alarm
    u_host.clear();
    @(posedge clk);
    #2;
    check(wrap_setting_alarm, 35'h0);
    repeat (3) @(posedge clk);
    conclude();
  end
endmodule // wzp_top_bench
`default_nettype wire
